// >>> hw/omc_pkg.sv
// ---------------------------------------------------------------------------
// Behaviour
// - power-on reset clears every state bit except interrupt status and mask to its reset value.
// - at start-up rc oscillator on, crystal off, cpu reset to address 0000.
// - port a wake leaves cold-domain bits untouched, except sleep request.
// - system reset clears global domain, port config domain only when enabled.
// - system reset keeps clock configuration except cpu clock; cpu is reset.
// - halt enters standby: cpu stopped, clocks keep running.
// - standby ends on any reset or an enabled interrupt or event.
// - sleep stops all circuit clocks and peripherals; no timekeeping. (the rc oscillator stays on in sleep while the bias bit is set)
// - sleep needs permit bit written first, then the request bit.
// - sleep wakes only on power-on, reset pin, port a combination or other reset request.
// - leaving sleep by power cycle marks ram contents as lost.
// - was-dozing flag reads 1 if sleep occurred since software cleared it.
// - sleep-domain reset stays asserted for the whole sleep period.
// - port config reset follows global reset when its enable bit is set.
// - sleep request bit reads 0 and is cleared by the global reset.
// ---------------------------------------------------------------------------
package omc_pkg;
   // register byte offsets
   localparam logic [7:0] OMC_SYSCTRL_OFS  = 8'h00;
   localparam logic [7:0] OMC_RSTSRC_OFS   = 8'h04;
   localparam logic [7:0] OMC_CLKSEL_OFS   = 8'h08;
   localparam logic [7:0] OMC_TRIMLO_OFS   = 8'h0c;
   localparam logic [7:0] OMC_TRIMHI_OFS   = 8'h10;
   localparam logic [7:0] OMC_MODE_OFS     = 8'h14;
   localparam logic [7:0] OMC_IRQSTAT_OFS  = 8'h18;
   localparam logic [7:0] OMC_IRQMASK_OFS  = 8'h1c;
   // system control fields
   localparam int OMC_PERMIT_BIT  = 7;
   localparam int OMC_PCFGEN_BIT  = 6;
   // reset source fields
   localparam int OMC_SLEEPREQ_BIT = 7;
   localparam int OMC_DOZED_BIT    = 6;
   localparam int OMC_COMBO_BIT    = 3;
   localparam int OMC_PAD_BIT      = 2;
   localparam int OMC_PADSLP_BIT   = 1;
   localparam int OMC_RAMLOST_BIT  = 0;
   // clock select fields
   localparam int OMC_EXTCLK_BIT  = 1;
   localparam int OMC_BIAS_BIT    = 0;
   localparam logic [1:0] OMC_CLKSEL_RST = 2'h1;
   localparam logic [7:0] OMC_TRIM_RST   = 8'h80;
   localparam logic [15:0] OMC_BOOT_ADDR = 16'h0000;
   // interrupt events
   localparam int OMC_EV_STANDBY = 0;
   localparam int OMC_EV_WAKE    = 1;
   localparam int OMC_EV_IGNORED = 2;
   localparam int OMC_EV_W       = 3;
   typedef enum logic [1:0] {OMC_ACTIVE, OMC_STANDBY, OMC_SLEEP} omc_mode_t;
endpackage : omc_pkg

// >>> hw/omc_sync3.sv
`timescale 1ns/10ps
// three-stage synchroniser; change accepted when stages one and two agree
module omc_sync3 (
   input  wire logic core_clk,
   input  wire logic resetn,
   input  wire logic din,
   output logic      dout
);
   logic [2:0] sh_q;
   // stage 0 is read only by stage 1
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         sh_q <= 3'h0;
         dout <= 1'b0;
      end else begin
         sh_q <= {sh_q[1:0], din};
         if (sh_q[1] == sh_q[2]) begin
            dout <= sh_q[2];
         end
      end
   end
endmodule : omc_sync3

// >>> hw/omc_axil.sv
`timescale 1ns/10ps
// axi4-lite slave front end; one write and one read at a time
module omc_axil (
   input  wire logic        core_clk,
   input  wire logic        resetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             wr_stb,
   output logic [7:0]       wr_addr,
   output logic [7:0]       wr_data,
   output logic             rd_stb,
   output logic [7:0]       rd_addr,
   input  wire logic [7:0]  rd_data,
   input  wire logic        rd_err,
   input  wire logic        wr_err
);
   logic       aw_q, w_q;
   logic [7:0] awa_q;
   logic [7:0] wd_q;

   assign s_axi_awready = !aw_q && !s_axi_bvalid;
   assign s_axi_wready  = !w_q && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign wr_stb  = aw_q && w_q;
   assign wr_addr = awa_q;
   assign wr_data = wd_q;
   assign rd_stb  = s_axi_arvalid && s_axi_arready;
   assign rd_addr = s_axi_araddr;

   // collect address and data in either order, then answer
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         aw_q <= 1'b0;
         w_q <= 1'b0;
         awa_q <= 8'h00;
         wd_q <= 8'h00;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_q <= 1'b1;
            awa_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_q <= 1'b1;
            wd_q <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
         end
         if (wr_stb) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_err ? 2'h2 : 2'h0;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // read data registered one cycle after the address is taken
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= 2'h0;
      end else if (rd_stb) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {24'h0, rd_data};
         s_axi_rresp <= rd_err ? 2'h2 : 2'h0;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule : omc_axil

// >>> hw/omc_top.sv
`timescale 1ns/10ps
module omc_top (
   input  wire logic        core_clk,
   input  wire logic        resetn,
   input  wire logic        por_active,
   input  wire logic        reset_pin,
   input  wire logic        wake_combination_reset,
   input  wire logic        other_reset_req,
   input  wire logic        halt_exec,
   input  wire logic        wake_request,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             cpu_reset,
   output logic [15:0]      cpu_start_addr,
   output logic             cpu_clk_en,
   output logic             periph_clk_en,
   output logic             rc_osc_en,
   output logic             xtal_osc_en,
   output logic             sleep_reset,
   output logic             global_reset,
   output logic             port_cfg_reset,
   output logic             irq
);
   // -------------------------------------------------------------------------
   // pin synchronisers and reset domains
   // -------------------------------------------------------------------------
   logic pin_s, combo_s, por_s;
   omc_sync3 u_pin (.core_clk(core_clk), .resetn(resetn), .din(reset_pin), .dout(pin_s));
   omc_sync3 u_combo (.core_clk(core_clk), .resetn(resetn), .din(wake_combination_reset),
                      .dout(combo_s));
   omc_sync3 u_por (.core_clk(core_clk), .resetn(resetn), .din(por_active), .dout(por_s));

   omc_pkg::omc_mode_t mode_q;
   logic       lowpower_entry_permit_q, port_cfg_reset_enable_q;
   logic       was_dozing_flag_q, combo_src_q, pad_src_q, padslp_src_q, ramlost_q;
   logic [1:0] clock_select_q;
   logic [7:0] rc_trim_low_q, rc_trim_high_q;
   logic [omc_pkg::OMC_EV_W-1:0] ev_stat_q, ev_mask_q, ev_set;
   logic       cold, sysrst;
   logic       wr_stb, rd_stb, wr_err, rd_err;
   logic [7:0] wr_addr, wr_data, rd_addr, rd_data;
   logic       sleep_go;

   // cold domain: power-on only; the reset pin stays in the global domain
   assign cold   = por_s;
   // global domain: any reset source, the port a wake included
   assign sysrst = cold || pin_s || combo_s || other_reset_req;
   assign global_reset   = sysrst;
   assign port_cfg_reset = sysrst && port_cfg_reset_enable_q;
   // cpu reset on any reset; never on an interrupt wake
   assign cpu_reset      = sysrst;
   assign cpu_start_addr = omc_pkg::OMC_BOOT_ADDR;
   // clocks stop in sleep; standby stops the cpu only
   assign cpu_clk_en    = (mode_q == omc_pkg::OMC_ACTIVE);
   assign periph_clk_en = (mode_q != omc_pkg::OMC_SLEEP);
   assign sleep_reset   = (mode_q == omc_pkg::OMC_SLEEP);
   // oscillators: rc on when awake or when the bias bit is set, crystal only when selected awake
   assign rc_osc_en   = !sleep_reset || clock_select_q[omc_pkg::OMC_BIAS_BIT];
   assign xtal_osc_en = !cold && !sleep_reset
                        && clock_select_q[omc_pkg::OMC_EXTCLK_BIT];

   // -------------------------------------------------------------------------
   // register bus
   // -------------------------------------------------------------------------
   omc_axil u_bus (
      .core_clk(core_clk), .resetn(resetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .wr_stb(wr_stb), .wr_addr(wr_addr), .wr_data(wr_data),
      .rd_stb(rd_stb), .rd_addr(rd_addr), .rd_data(rd_data),
      .rd_err(rd_err), .wr_err(wr_err)
   );

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   function automatic logic mapped(input logic [7:0] a);
      mapped = hit(a, omc_pkg::OMC_SYSCTRL_OFS) || hit(a, omc_pkg::OMC_RSTSRC_OFS)
            || hit(a, omc_pkg::OMC_CLKSEL_OFS)  || hit(a, omc_pkg::OMC_TRIMLO_OFS)
            || hit(a, omc_pkg::OMC_TRIMHI_OFS)  || hit(a, omc_pkg::OMC_MODE_OFS)
            || hit(a, omc_pkg::OMC_IRQSTAT_OFS) || hit(a, omc_pkg::OMC_IRQMASK_OFS);
   endfunction : mapped

   assign wr_err = !mapped(wr_addr);
   assign rd_err = !mapped(rd_addr);

   logic wr_ctrl, wr_rsrc, rd_rsrc, rd_stat;
   assign wr_ctrl = wr_stb && hit(wr_addr, omc_pkg::OMC_SYSCTRL_OFS);
   assign wr_rsrc = wr_stb && hit(wr_addr, omc_pkg::OMC_RSTSRC_OFS);
   assign rd_rsrc = rd_stb && hit(rd_addr, omc_pkg::OMC_RSTSRC_OFS);
   assign rd_stat = rd_stb && hit(rd_addr, omc_pkg::OMC_IRQSTAT_OFS);

   // read mux; sleep request bit is never stored, so it always reads 0
   always_comb begin
      rd_data = 8'h00;
      if (hit(rd_addr, omc_pkg::OMC_SYSCTRL_OFS)) begin
         rd_data[omc_pkg::OMC_PERMIT_BIT] = lowpower_entry_permit_q;
         rd_data[omc_pkg::OMC_PCFGEN_BIT] = port_cfg_reset_enable_q;
      end else if (hit(rd_addr, omc_pkg::OMC_RSTSRC_OFS)) begin
         rd_data[omc_pkg::OMC_DOZED_BIT]   = was_dozing_flag_q;
         rd_data[omc_pkg::OMC_COMBO_BIT]   = combo_src_q;
         rd_data[omc_pkg::OMC_PAD_BIT]     = pad_src_q;
         rd_data[omc_pkg::OMC_PADSLP_BIT]  = padslp_src_q;
         rd_data[omc_pkg::OMC_RAMLOST_BIT] = ramlost_q;
      end else if (hit(rd_addr, omc_pkg::OMC_CLKSEL_OFS)) begin
         rd_data = {6'h00, clock_select_q};
      end else if (hit(rd_addr, omc_pkg::OMC_TRIMLO_OFS)) begin
         rd_data = rc_trim_low_q;
      end else if (hit(rd_addr, omc_pkg::OMC_TRIMHI_OFS)) begin
         rd_data = rc_trim_high_q;
      end else if (hit(rd_addr, omc_pkg::OMC_MODE_OFS)) begin
         rd_data = {6'h00, mode_q};
      end else if (hit(rd_addr, omc_pkg::OMC_IRQSTAT_OFS)) begin
         rd_data = {5'h00, ev_stat_q};
      end else if (hit(rd_addr, omc_pkg::OMC_IRQMASK_OFS)) begin
         rd_data = {5'h00, ev_mask_q};
      end
   end

   // -------------------------------------------------------------------------
   // cold-domain registers: only power-on clears them, so a port a wake keeps them
   // -------------------------------------------------------------------------
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         lowpower_entry_permit_q <= 1'b0;
         port_cfg_reset_enable_q <= 1'b0;
         clock_select_q <= omc_pkg::OMC_CLKSEL_RST;
         rc_trim_low_q  <= omc_pkg::OMC_TRIM_RST;
         rc_trim_high_q <= omc_pkg::OMC_TRIM_RST;
      end else if (cold) begin
         lowpower_entry_permit_q <= 1'b0;
         port_cfg_reset_enable_q <= 1'b0;
         clock_select_q <= omc_pkg::OMC_CLKSEL_RST;
         rc_trim_low_q  <= omc_pkg::OMC_TRIM_RST;
         rc_trim_high_q <= omc_pkg::OMC_TRIM_RST;
      end else if (wr_stb) begin                                   // kept on sysrst
         if (wr_ctrl) begin
            lowpower_entry_permit_q <= wr_data[omc_pkg::OMC_PERMIT_BIT];
            port_cfg_reset_enable_q <= wr_data[omc_pkg::OMC_PCFGEN_BIT];
         end
         if (hit(wr_addr, omc_pkg::OMC_CLKSEL_OFS)) begin
            clock_select_q <= wr_data[1:0];
         end
         if (hit(wr_addr, omc_pkg::OMC_TRIMLO_OFS)) begin
            rc_trim_low_q <= wr_data;
         end
         if (hit(wr_addr, omc_pkg::OMC_TRIMHI_OFS)) begin
            rc_trim_high_q <= wr_data;
         end
      end
   end

   // sleep request takes effect only when already permitted by an earlier write
   assign sleep_go = wr_rsrc && wr_data[omc_pkg::OMC_SLEEPREQ_BIT]
                     && lowpower_entry_permit_q && !sysrst;

   // -------------------------------------------------------------------------
   // operating mode
   // -------------------------------------------------------------------------
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         mode_q <= omc_pkg::OMC_ACTIVE;
      end else if (sysrst) begin
         mode_q <= omc_pkg::OMC_ACTIVE;
      end else begin
         unique case (mode_q)
            omc_pkg::OMC_ACTIVE: begin
               if (sleep_go) begin
                  mode_q <= omc_pkg::OMC_SLEEP;
               end else if (halt_exec) begin
                  mode_q <= omc_pkg::OMC_STANDBY;
               end
            end
            // interrupts leave standby without touching cpu state
            omc_pkg::OMC_STANDBY: begin
               if (wake_request) begin
                  mode_q <= omc_pkg::OMC_ACTIVE;
               end
            end
            // only resets end sleep; interrupts are deaf here
            omc_pkg::OMC_SLEEP: mode_q <= omc_pkg::OMC_SLEEP;
            default: mode_q <= omc_pkg::OMC_ACTIVE;
         endcase
      end
   end

   // -------------------------------------------------------------------------
   // reset-source flags: set wins over the read clear
   // -------------------------------------------------------------------------
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         was_dozing_flag_q <= 1'b0;
         combo_src_q <= 1'b0;
         pad_src_q <= 1'b0;
         padslp_src_q <= 1'b0;
         ramlost_q <= 1'b1;
      end else if (cold) begin
         was_dozing_flag_q <= 1'b0;
         combo_src_q <= 1'b0;
         pad_src_q <= 1'b0;
         padslp_src_q <= 1'b0;
         ramlost_q <= 1'b1;
      end else begin
         if (wr_rsrc && !wr_data[omc_pkg::OMC_DOZED_BIT]) begin
            was_dozing_flag_q <= 1'b0;
         end
         if (rd_rsrc) begin
            combo_src_q <= 1'b0;
            pad_src_q <= 1'b0;
            padslp_src_q <= 1'b0;
            ramlost_q <= 1'b0;
         end
         if (mode_q == omc_pkg::OMC_SLEEP) begin
            was_dozing_flag_q <= 1'b1;
         end
         if (combo_s) begin
            combo_src_q <= 1'b1;
         end
         if (pin_s) begin
            pad_src_q <= 1'b1;
            // only a pin reset seen in sleep sets it; a read clear must not be undone
            if (mode_q == omc_pkg::OMC_SLEEP) begin
               padslp_src_q <= 1'b1;
            end
         end
      end
   end

   // -------------------------------------------------------------------------
   // interrupts: sticky status cleared by reading it, mask gates the line
   // -------------------------------------------------------------------------
   assign ev_set = {sysrst == 1'b0 && wr_rsrc && wr_data[omc_pkg::OMC_SLEEPREQ_BIT]
                      && !lowpower_entry_permit_q,
                    (mode_q == omc_pkg::OMC_STANDBY) && wake_request && !sysrst,
                    (mode_q == omc_pkg::OMC_ACTIVE) && halt_exec && !sleep_go && !sysrst};

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         ev_stat_q <= '0;
         ev_mask_q <= '0;
      end else begin
         ev_stat_q <= (rd_stat ? '0 : ev_stat_q) | ev_set;
         if (wr_stb && hit(wr_addr, omc_pkg::OMC_IRQMASK_OFS)) begin
            ev_mask_q <= wr_data[omc_pkg::OMC_EV_W-1:0];
         end
      end
   end
   assign irq = |(ev_stat_q & ev_mask_q);

   // -------------------------------------------------------------------------
   // checks
   // -------------------------------------------------------------------------
   sequence permit_then_req;
      mode_q == omc_pkg::OMC_ACTIVE && lowpower_entry_permit_q && wr_rsrc
      && wr_data[omc_pkg::OMC_SLEEPREQ_BIT] && !sysrst;
   endsequence
   sleep_entry_a: assert property (@(posedge core_clk) disable iff (!resetn)
      permit_then_req |=> mode_q == omc_pkg::OMC_SLEEP) else $error("sleep not entered");
   sleep_denied_a: assert property (@(posedge core_clk) disable iff (!resetn)
      (mode_q == omc_pkg::OMC_ACTIVE && !lowpower_entry_permit_q)
      |=> mode_q != omc_pkg::OMC_SLEEP) else $error("sleep without permit");
   sleep_clocks_a: assert property (@(posedge core_clk) disable iff (!resetn)
      mode_q == omc_pkg::OMC_SLEEP |-> !periph_clk_en && !cpu_clk_en && sleep_reset)
      else $error("clocks running in sleep");
   sleep_hold_a: assert property (@(posedge core_clk) disable iff (!resetn)
      (mode_q == omc_pkg::OMC_SLEEP && !sysrst) |=> mode_q == omc_pkg::OMC_SLEEP)
      else $error("sleep left without reset");
   standby_halt_a: assert property (@(posedge core_clk) disable iff (!resetn)
      (mode_q == omc_pkg::OMC_STANDBY) |-> !cpu_clk_en && periph_clk_en)
      else $error("standby clocks wrong");
   standby_wake_a: assert property (@(posedge core_clk) disable iff (!resetn)
      (mode_q == omc_pkg::OMC_STANDBY && wake_request) |=> mode_q == omc_pkg::OMC_ACTIVE
      && !cpu_reset) else $error("standby wake failed");
   pcfg_reset_a: assert property (@(posedge core_clk) disable iff (!resetn)
      port_cfg_reset == (global_reset && port_cfg_reset_enable_q))
      else $error("port cfg reset wrong");
   dozing_flag_a: assert property (@(posedge core_clk) disable iff (!resetn)
      (mode_q == omc_pkg::OMC_SLEEP && !cold) |=> was_dozing_flag_q)
      else $error("dozing flag not set");
   cold_keep_a: assert property (@(posedge core_clk) disable iff (!resetn)
      (!cold && !wr_stb) |=> $stable(rc_trim_low_q) && $stable(clock_select_q))
      else $error("cold bits changed");
endmodule : omc_top

// >>> verif/omc_far_model.sv
`timescale 1ns/10ps
// cpu side: a halt request retires as one single-cycle pulse
module omc_far_model (
   input  wire logic core_clk,
   input  wire logic halt_cmd,
   output logic      halt_exec
);
   logic cmd_q;
   // edge detect, so a held request is never seen as two halts
   always_ff @(posedge core_clk) begin
      cmd_q     <= halt_cmd;
      halt_exec <= halt_cmd & ~cmd_q;
   end
endmodule : omc_far_model

// >>> verif/operating_mode_controller_tb_top.sv
`timescale 1ns/10ps
module operating_mode_controller_tb_top;
   logic        core_clk, resetn, por_active, reset_pin, wake_combination_reset;
   logic        other_reset_req, halt_exec, halt_cmd, wake_request;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rv;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready, cpu_reset, cpu_clk_en, periph_clk_en;
   logic        rc_osc_en, xtal_osc_en, sleep_reset, global_reset, port_cfg_reset, irq;
   logic [15:0] cpu_start_addr;
   int          bad_count, n_compared;

   omc_top DUT (.core_clk, .resetn, .por_active, .reset_pin, .wake_combination_reset,
      .other_reset_req, .halt_exec, .wake_request, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .cpu_reset, .cpu_start_addr, .cpu_clk_en, .periph_clk_en, .rc_osc_en,
      .xtal_osc_en, .sleep_reset, .global_reset, .port_cfg_reset, .irq);
   omc_far_model FAR (.core_clk, .halt_cmd, .halt_exec);

   // 40 mhz clock
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   task finish_test(input logic to);
      if (to) bad_count++;
      if (bad_count == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : finish_test

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask : chk

   task cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask : cyc

   // address and data offered together, each dropped once taken
   task wr(input logic [7:0] a, input logic [7:0] d);
      int i;
      @(posedge core_clk);
      {s_axi_awaddr, s_axi_wdata} <= {a, 24'h0, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
      for (i = 0; i < 50; i++) begin
         @(posedge core_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      rr = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (i == 50) finish_test(1'b1);
   endtask : wr

   task rd(input logic [7:0] a);
      int i;
      @(posedge core_clk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'b11;
      for (i = 0; i < 50; i++) begin
         @(posedge core_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      {rv, rr} = {s_axi_rdata, s_axi_rresp};
      s_axi_rready <= 1'b0;
      if (i == 50) finish_test(1'b1);
   endtask : rd

   // main sequence; pulses are held long enough for the input synchronisers
   initial begin
      {resetn, por_active, reset_pin, wake_combination_reset, other_reset_req} = '0;
      {halt_cmd, wake_request, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'h1;
      {bad_count, n_compared} = '0;
      cyc(8);
      resetn <= 1'b1;
      rd(8'h08); chk("clksel", 32'h1, rv);
      rd(8'h0c); chk("trim", 32'h80, rv);
      chk("osc", 32'h20000, {rc_osc_en, xtal_osc_en, cpu_start_addr});
      rd(8'h40); chk("slverr", 32'h2, {30'h0, rr});
      wr(8'h40, 8'h00); chk("bresp", 32'h2, {30'h0, rr});
      wr(8'h1c, 8'h04); chk("bresp", 32'h0, {30'h0, rr});
      wr(8'h04, 8'h80);
      cyc(3); chk("irq", 32'h1, {31'h0, irq});
      rd(8'h14); chk("mode", 32'h0, rv);
      rd(8'h18); chk("irqst", 32'h4, rv);
      cyc(2); chk("irqclr", 32'h0, {31'h0, irq});
      wr(8'h08, 8'h00);
      wr(8'h00, 8'h80);
      wr(8'h04, 8'h80);
      cyc(20);
      chk("sleep", 32'h4, {sleep_reset, periph_clk_en, cpu_clk_en});
      wake_combination_reset <= 1'b1;
      cyc(8);
      wake_combination_reset <= 1'b0;
      cyc(8);
      rd(8'h14); chk("mode", 32'h0, rv);
      rd(8'h00); chk("sysctrl", 32'h80, rv);
      rd(8'h08); chk("clksel", 32'h0, rv);
      rd(8'h04); chk("rstsrc", 32'h49, rv);
      wr(8'h04, 8'h00);
      rd(8'h04); chk("rstsrc", 32'h0, rv);
      wr(8'h1c, 8'h03);
      halt_cmd <= 1'b1;
      cyc(4);
      halt_cmd <= 1'b0;
      chk("standby", 32'h1, {cpu_clk_en, periph_clk_en});
      wake_request <= 1'b1;
      cyc(4);
      wake_request <= 1'b0;
      rd(8'h14); chk("mode", 32'h0, rv);
      chk("cpurst", 32'h0, {31'h0, cpu_reset});
      rd(8'h18); chk("irqst", 32'h3, rv);
      wr(8'h00, 8'hc0);
      other_reset_req <= 1'b1;
      cyc(4); chk("rst", 32'h7, {global_reset, port_cfg_reset, cpu_reset});
      other_reset_req <= 1'b0;
      cyc(4);
      rd(8'h08); chk("clksel", 32'h0, rv);
      wr(8'h00, 8'h80);
      other_reset_req <= 1'b1;
      cyc(4); chk("rst", 32'h5, {global_reset, port_cfg_reset, cpu_reset});
      other_reset_req <= 1'b0;
      wr(8'h04, 8'h80);
      por_active <= 1'b1;
      cyc(8);
      por_active <= 1'b0;
      cyc(8);
      rd(8'h00); chk("sysctrl", 32'h0, rv);
      rd(8'h04); chk("ramlost", 32'h1, rv & 32'h1);
      finish_test(1'b0);
   end
endmodule : operating_mode_controller_tb_top
